/* File: cache_bus_regs.svh */
// constants for the cache snoop and burst bus controller
// assumes a single 10 MHz bus clock shared with all bus parties
`ifndef CACHE_BUS_REGS_SVH
`define CACHE_BUS_REGS_SVH
`define WAYS    4
`define WAY_W   2
`define SETS    16
`define IDX_W   4
`define OFS_W   4
`define TAG_W   24
`define BEATS   4
`define BEAT_W  2
`define WORD_W  32
`define LINE_W  128
`endif

/* File: cache_bus_pkg.sv */
// types shared by the snoop and burst bus controller
// assumes cache_bus_regs.svh is on the include path
`include "cache_bus_regs.svh"
package cache_bus_pkg;
  typedef enum logic [1:0] {LINE_INV, LINE_VAL, LINE_DIRTY} line_e;
  typedef enum logic [2:0] {
    BUS_IDLE, BUS_RADDR, BUS_RDATA, BUS_WADDR, BUS_WDATA
  } bus_e;
  typedef logic [`TAG_W-1:0] tag_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        instr;
    logic [31:0] addr;
  } core_req_s;
  typedef struct packed {
    logic               valid;
    logic               copyback;
    logic               instr;
    logic [31:0]        addr;
    logic [`LINE_W-1:0] line;
  } bus_req_s;
endpackage

/* File: cache_snoop_burst_bus_ctrl.sv */
// cache tag store, bus snooper, burst bus controller and standby
// assumes other masters put the snoop address on adIn with extStart
`timescale 1ns/1ps
`include "cache_bus_regs.svh"
module cache_snoop_burst_bus_ctrl (
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire cache_bus_pkg::core_req_s coreReq,
  output logic                       coreGrant,
  output logic                       coreHit_r,
  output logic                       coreDone_r,
  input  wire cache_bus_pkg::bus_req_s  busReq,
  output logic                       busReqReady,
  output logic [`WORD_W-1:0]         fillWord_r,
  output logic                       fillWordValid_r,
  output logic                       fillDone_r,
  input  wire logic [`WORD_W-1:0]    adIn,
  output logic [`WORD_W-1:0]         adOut_r,
  output logic                       adOe_r,
  output logic                       busStart_r,
  output logic                       busWrite_r,
  input  wire logic                  busAck,
  input  wire logic                  extStart,
  input  wire logic                  extWrite,
  input  wire logic                  extSnoop,
  output logic                       snoopConflict_r,
  input  wire logic                  lowPowerStop,
  input  wire logic                  intValid,
  output logic                       standby_r
);
  import cache_bus_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  function automatic logic [2:0] findWay(input tag_t tags [`WAYS],
    input logic [`WAYS-1:0] vld, input tag_t tag);
    logic [2:0] res;
    res = 3'h0;
    for (int w = 0; w < `WAYS; w++)
      if (vld[w] && tags[w] == tag)
        res = {1'b1, w[`WAY_W-1:0]};
    return res;
  endfunction
  ////////////////////////////////////////////////////////////////////
  // tag store
  tag_t               dTag_r [`SETS][`WAYS], dTag_nxt [`SETS][`WAYS];
  line_e              dSt_r  [`SETS][`WAYS], dSt_nxt  [`SETS][`WAYS];
  tag_t               iTag_r [`SETS][`WAYS], iTag_nxt [`SETS][`WAYS];
  logic [`WAYS-1:0]   iVal_r [`SETS],        iVal_nxt [`SETS];
  logic [`WAY_W-1:0]  vict_r, vict_nxt;
  logic               fillCommit;
  bus_req_s           req_r, req_nxt;
  logic [`IDX_W-1:0]  fIdx;
  tag_t               fTag;
  ////////////////////////////////////////////////////////////////////
  // snoop stage
  logic               snoopV_r, snoopV_nxt, snoopWr_r, snoopWr_nxt;
  logic [31:0]        snoopAddr_r, snoopAddr_nxt;
  logic               snoopConflict_nxt;
  logic [`IDX_W-1:0]  sIdx;
  tag_t               sTag;
  logic [`WAYS-1:0]   dVldS;
  logic [2:0]         dS, iS;
  logic               dSnoopEn, iSnoopEn, dSnoopHit, iSnoopHit;
  always_comb
  begin
    snoopV_nxt    = extStart && extSnoop;
    snoopWr_nxt   = extWrite;
    snoopAddr_nxt = adIn;
    sIdx          = snoopAddr_r[`OFS_W +: `IDX_W];
    sTag          = snoopAddr_r[31 -: `TAG_W];
    for (int w = 0; w < `WAYS; w++)
      dVldS[w] = dSt_r[sIdx][w] != LINE_INV;
    dS        = findWay(dTag_r[sIdx], dVldS, sTag);
    iS        = findWay(iTag_r[sIdx], iVal_r[sIdx], sTag);
    dSnoopEn  = snoopV_r;
    iSnoopEn  = snoopV_r && snoopWr_r;
    dSnoopHit = dSnoopEn && dS[2];
    iSnoopHit = iSnoopEn && iS[2];
    snoopConflict_nxt = dSnoopHit
      && dSt_r[sIdx][dS[`WAY_W-1:0]] == LINE_DIRTY;
  end
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      snoopV_r        <= 1'b0;
      snoopWr_r       <= 1'b0;
      snoopAddr_r     <= 32'h0;
      snoopConflict_r <= 1'b0;
    end
    else
    begin
      snoopV_r        <= snoopV_nxt;
      snoopWr_r       <= snoopWr_nxt;
      snoopAddr_r     <= snoopAddr_nxt;
      snoopConflict_r <= snoopConflict_nxt;
    end
  end
  chk_nosnoop_ignored: assert property (
    extStart && !extSnoop |=> !snoopV_r && !snoopConflict_r ##1
      !snoopConflict_r)
    else $error("nonsnoopable cycle was snooped");
  chk_write_both_caches: assert property (
    extStart && extSnoop && extWrite |=> dSnoopEn && iSnoopEn)
    else $error("snooped write missed a cache");
  chk_read_data_only: assert property (
    extStart && extSnoop && !extWrite |=> dSnoopEn && !iSnoopEn)
    else $error("snooped read looked in instruction cache");
  chk_dirty_conflict: assert property (
    dSnoopHit && dSt_r[sIdx][dS[1:0]] == LINE_DIRTY |=> snoopConflict_r)
    else $error("dirty snoop hit not flagged");
  chk_write_invalidates: assert property (
    iSnoopHit && !fillCommit |=> !iVal_r[$past(sIdx)][$past(iS[1:0])])
    else $error("snooped write hit left line valid");
  ////////////////////////////////////////////////////////////////////
  // core lookups and standby
  logic [`IDX_W-1:0]  cIdx;
  tag_t               cTag;
  logic [`WAYS-1:0]   dVldC;
  logic [2:0]         cd, ci;
  logic               coreHit_nxt, standby_nxt;
  always_comb
  begin
    cIdx = coreReq.addr[`OFS_W +: `IDX_W];
    cTag = coreReq.addr[31 -: `TAG_W];
    for (int w = 0; w < `WAYS; w++)
      dVldC[w] = dSt_r[cIdx][w] != LINE_INV;
    cd = findWay(dTag_r[cIdx], dVldC, cTag);
    ci = findWay(iTag_r[cIdx], iVal_r[cIdx], cTag);
    coreGrant = coreReq.valid && !standby_r
      && !(coreReq.instr ? iSnoopEn : dSnoopEn);
    coreHit_nxt = coreGrant && (coreReq.instr ? ci[2] : cd[2]);
    standby_nxt = standby_r ? !intValid : lowPowerStop;
  end
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      coreHit_r  <= 1'b0;
      coreDone_r <= 1'b0;
      standby_r  <= 1'b0;
    end
    else
    begin
      coreHit_r  <= coreHit_nxt;
      coreDone_r <= coreGrant;
      standby_r  <= standby_nxt;
    end
  end
  chk_snoop_first: assert property (
    snoopV_r && coreReq.valid && !coreReq.instr |-> !coreGrant)
    else $error("core granted over snoop");
  chk_stop_halts: assert property (
    !standby_r && lowPowerStop |=> standby_r && !coreGrant)
    else $error("stop did not halt execution");
  chk_stay_standby: assert property (
    standby_r && !intValid |=> standby_r && !busReqReady)
    else $error("standby left without interrupt");
  ////////////////////////////////////////////////////////////////////
  // tag store update
  always_comb
  begin
    dTag_nxt = dTag_r;
    dSt_nxt  = dSt_r;
    iTag_nxt = iTag_r;
    iVal_nxt = iVal_r;
    vict_nxt = vict_r;
    if (coreGrant && coreReq.write && !coreReq.instr && cd[2])
      dSt_nxt[cIdx][cd[1:0]] = LINE_DIRTY;
    if (iSnoopHit)
      iVal_nxt[sIdx][iS[1:0]] = 1'b0;
    if (dSnoopHit && snoopWr_r)
      dSt_nxt[sIdx][dS[1:0]] = LINE_INV;
    if (fillCommit)
    begin
      vict_nxt = vict_r + 2'h1;
      if (req_r.instr)
      begin
        iTag_nxt[fIdx][vict_r] = fTag;
        iVal_nxt[fIdx][vict_r] = 1'b1;
      end
      else
      begin
        dTag_nxt[fIdx][vict_r] = fTag;
        dSt_nxt[fIdx][vict_r]  = LINE_VAL;
      end
    end
  end
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      vict_r <= 2'h0;
      for (int s = 0; s < `SETS; s++)
      begin
        iVal_r[s] <= 4'h0;
        for (int w = 0; w < `WAYS; w++)
          dSt_r[s][w] <= LINE_INV; // tags unused while invalid
      end
    end
    else
    begin
      vict_r <= vict_nxt;
      dSt_r  <= dSt_nxt;
      dTag_r <= dTag_nxt;
      iTag_r <= iTag_nxt;
      iVal_r <= iVal_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // burst bus controller
  bus_e               bstate_r, bstate_nxt;
  logic [`BEAT_W-1:0] beat_r, beat_nxt;
  logic [`WORD_W-1:0] adOut_nxt, fillWord_nxt;
  logic               adOe_nxt, busStart_nxt, busWrite_nxt;
  logic               fillWordValid_nxt, fillDone_nxt;
  always_comb
  begin
    bstate_nxt        = bstate_r;
    req_nxt           = req_r;
    beat_nxt          = beat_r;
    adOut_nxt         = adOut_r;
    adOe_nxt          = adOe_r;
    busWrite_nxt      = busWrite_r;
    fillWord_nxt      = fillWord_r;
    busStart_nxt      = 1'b0;
    fillWordValid_nxt = 1'b0;
    fillDone_nxt      = 1'b0;
    fillCommit        = 1'b0;
    fIdx              = req_r.addr[`OFS_W +: `IDX_W];
    fTag              = req_r.addr[31 -: `TAG_W];
    busReqReady       = bstate_r == BUS_IDLE && !standby_r;
    unique case (bstate_r)
      BUS_IDLE:
        if (busReq.valid && busReqReady)
        begin
          req_nxt      = busReq;
          adOut_nxt    = {busReq.addr[31:`OFS_W], 4'h0};
          adOe_nxt     = 1'b1;
          busStart_nxt = 1'b1;
          busWrite_nxt = busReq.copyback;
          beat_nxt     = 2'h0;
          bstate_nxt   = busReq.copyback ? BUS_WADDR : BUS_RADDR;
        end
      BUS_RADDR:
      begin
        adOe_nxt   = 1'b0;
        bstate_nxt = BUS_RDATA;
      end
      BUS_RDATA:
        if (busAck)
        begin
          fillWord_nxt      = adIn;
          fillWordValid_nxt = 1'b1;
          beat_nxt          = beat_r + 2'h1;
          if (beat_r == 2'(`BEATS - 1))
          begin
            fillCommit   = 1'b1;
            fillDone_nxt = 1'b1;
            busWrite_nxt = 1'b0;
            bstate_nxt   = BUS_IDLE;
          end
        end
      BUS_WADDR:
      begin
        adOut_nxt  = req_r.line[0 +: `WORD_W];
        bstate_nxt = BUS_WDATA;
      end
      BUS_WDATA:
        if (beat_r == 2'(`BEATS - 1))
        begin
          adOe_nxt     = 1'b0;
          busWrite_nxt = 1'b0;
          bstate_nxt   = BUS_IDLE;
        end
        else
        begin
          beat_nxt  = beat_r + 2'h1;
          adOut_nxt = req_r.line[`WORD_W * (int'(beat_r) + 1) +: `WORD_W];
        end
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      bstate_r        <= BUS_IDLE;
      req_r           <= '0;
      beat_r          <= 2'h0;
      adOut_r         <= 32'h0;
      adOe_r          <= 1'b0;
      busStart_r      <= 1'b0;
      busWrite_r      <= 1'b0;
      fillWord_r      <= 32'h0;
      fillWordValid_r <= 1'b0;
      fillDone_r      <= 1'b0;
    end
    else
    begin
      bstate_r        <= bstate_nxt;
      req_r           <= req_nxt;
      beat_r          <= beat_nxt;
      adOut_r         <= adOut_nxt;
      adOe_r          <= adOe_nxt;
      busStart_r      <= busStart_nxt;
      busWrite_r      <= busWrite_nxt;
      fillWord_r      <= fillWord_nxt;
      fillWordValid_r <= fillWordValid_nxt;
      fillDone_r      <= fillDone_nxt;
    end
  end
  logic [2:0] fillAcks;
  always_ff @(posedge clock)
  begin
    if (srst || busStart_r)
      fillAcks <= 3'h0;
    else if (fillWordValid_r)
      fillAcks <= fillAcks + 3'h1;
  end
  chk_addr_phase: assert property (
    busStart_r |-> adOe_r && adOut_r == {req_r.addr[31:4], 4'h0})
    else $error("address phase not driven");
  chk_fill_four: assert property (
    fillDone_r |-> fillWordValid_r && fillAcks == 3'h3)
    else $error("fill burst not four words");
  chk_write_five: assert property (
    busStart_r && busWrite_r |-> adOe_r ##1 (adOe_r && busWrite_r)[*4]
      ##1 !adOe_r && bstate_r == BUS_IDLE)
    else $error("burst write not five clocks");
  chk_core_concurrent: assert property (
    bstate_r != BUS_IDLE && coreReq.valid && !snoopV_r && !standby_r
      |-> coreGrant)
    else $error("core stalled by bus activity");
endmodule

/* File: mem_model.sv */
// memory side of the burst bus: answers line fills, captures copybacks
// assumes device outputs registered on the same rising clock edge
`timescale 1ns/1ps
module mem_model (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic         slow,
  input  wire logic [31:0]  adOut,
  input  wire logic         adOe,
  input  wire logic         start,
  input  wire logic         wr,
  output logic [31:0]       rdData_r,
  output logic              ack_r,
  output logic [127:0]      wrLine_r,
  output logic [3:0]        wrClk_r
);
  logic [31:0] base_r;
  logic [2:0]  beat_r;
  logic [1:0]  wIdx_r;
  logic        rdAct_r;
  logic        hold_r;
  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdAct_r  <= 1'b0;
      ack_r    <= 1'b0;
      hold_r   <= 1'b0;
      wrClk_r  <= 4'h0;
      rdData_r <= 32'h0;
    end
    else
    begin
      ack_r    <= 1'b0;
      rdData_r <= ~rdData_r; // released bus keeps moving
      hold_r   <= slow & ~hold_r;
      wrClk_r  <= start ? 4'h1 : wrClk_r + {3'h0, wr};
      if (start & ~wr)
      begin
        rdAct_r <= 1'b1;
        base_r  <= adOut;
        beat_r  <= 3'h0;
      end
      else if (rdAct_r & ~(slow & ~hold_r))
      begin
        ack_r    <= 1'b1; // one word per clock unless slow
        rdData_r <= {base_r[31:4], beat_r[1:0], 2'h0} ^ 32'h5a5a0000;
        beat_r   <= beat_r + 3'h1;
        rdAct_r  <= beat_r != 3'h3;
      end
      if (start & wr)
        wIdx_r <= 2'h0;
      else if (adOe & wr)
      begin
        wrLine_r[{wIdx_r, 5'h0} +: 32] <= adOut; // word per clock
        wIdx_r <= wIdx_r + 2'h1;
      end
    end
  end
endmodule

/* File: cache_snoop_burst_bus_ctrl_test.sv */
// self-checking bench for the snoop and burst bus controller
// assumes mem_model answers bursts; bench plays the other bus master
`timescale 1ns/1ps
module cache_snoop_burst_bus_ctrl_test;
  import cache_bus_pkg::*;
  logic clock = 0, srst = 1, extStart = 0, extWrite = 0, extSnoop = 0;
  logic lowPowerStop = 0, intValid = 0, slow = 0, tbDrive = 0;
  logic [31:0]  tbAd = 32'h0;
  core_req_s    coreReq = '0;
  bus_req_s     busReq = '0;
  logic coreGrant, coreHit_r, coreDone_r, busReqReady, fillWordValid_r;
  logic fillDone_r, adOe_r, busStart_r, busWrite_r, snoopConflict_r;
  logic standby_r, ack;
  logic [31:0]  fillWord_r, adOut_r, rdData;
  logic [127:0] wrLine;
  logic [3:0]   wrClk;
  int error_cnt = 0, checks_done = 0;
  localparam logic [31:0] A = 32'h00001230, B = 32'h00004560;
  always #50 clock = ~clock;
  cache_snoop_burst_bus_ctrl u_dut (.clock(clock), .srst(srst),
    .coreReq(coreReq), .coreGrant(coreGrant), .coreHit_r(coreHit_r),
    .coreDone_r(coreDone_r), .busReq(busReq), .busReqReady(busReqReady),
    .fillWord_r(fillWord_r), .fillWordValid_r(fillWordValid_r),
    .fillDone_r(fillDone_r), .adIn(tbDrive ? tbAd : rdData),
    .adOut_r(adOut_r), .adOe_r(adOe_r), .busStart_r(busStart_r),
    .busWrite_r(busWrite_r), .busAck(ack), .extStart(extStart),
    .extWrite(extWrite), .extSnoop(extSnoop),
    .snoopConflict_r(snoopConflict_r), .lowPowerStop(lowPowerStop),
    .intValid(intValid), .standby_r(standby_r));
  mem_model u_mem (.clock(clock), .srst(srst), .slow(slow),
    .adOut(adOut_r), .adOe(adOe_r), .start(busStart_r),
    .wr(busWrite_r), .rdData_r(rdData), .ack_r(ack),
    .wrLine_r(wrLine), .wrClk_r(wrClk));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [127:0] e, g);
    checks_done++;
    if (e !== g)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] mw(logic [31:0] a, int k);
    return {a[31:4], k[1:0], 2'h0} ^ 32'h5a5a0000;
  endfunction
  task automatic look(input logic i, w, input logic [31:0] a, input logic h);
    int n = 0;
    @(negedge clock);
    coreReq = '{1'b1, w, i, a};
    #1;
    while (coreGrant !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      #1;
      n++;
    end
    @(negedge clock);
    coreReq.valid = 1'b0;
    chk("done", 1, coreDone_r);
    chk("hit", h, coreHit_r);
  endtask
  task automatic waitRdy;
    int n = 0;
    #1;
    while (busReqReady !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      #1;
      n++;
    end
    @(negedge clock);
    busReq.valid = 1'b0;
  endtask
  task automatic fill(input logic i, input logic [31:0] a);
    int n, k = 0;
    @(negedge clock);
    busReq = '{1'b1, 1'b0, i, a, 128'h0};
    waitRdy();
    chk("start", 1, busStart_r);
    chk("addr", a & ~32'hf, adOut_r);
    chk("oe", 1, adOe_r);
    for (n = 0; n < 40 && k < 4; n++)
    begin
      @(negedge clock);
      if (fillWordValid_r === 1'b1)
      begin
        chk("fill", mw(a, k), fillWord_r);
        chk("last", k == 3, fillDone_r);
        k++;
      end
    end
    chk("beats", 4, k);
  endtask
  task automatic snp(input logic w, s, input logic [31:0] a, input logic c);
    @(negedge clock);
    {extStart, extWrite, extSnoop, tbAd, tbDrive} = {1'b1, w, s, a, 1'b1};
    @(negedge clock);
    {extStart, tbDrive} = 2'h0;
    @(negedge clock);
    chk("conflict", c, snoopConflict_r);
  endtask
  task automatic prio(input logic [31:0] a);
    @(negedge clock);
    {extStart, extWrite, extSnoop, tbAd, tbDrive} = {1'b1, 1'b0, 1'b1, a, 1'b1};
    @(negedge clock);
    {extStart, tbDrive} = 2'h0;
    coreReq = '{1'b1, 1'b0, 1'b0, a};
    #1;
    chk("dgrant", 0, coreGrant);
    coreReq.instr = 1'b1;
    #1;
    chk("igrant", 1, coreGrant);
    coreReq.valid = 1'b0;
    look(0, 0, a, 1);
  endtask
  task automatic cb(input logic [31:0] a, input logic [127:0] l);
    int n = 0;
    @(negedge clock);
    busReq = '{1'b1, 1'b1, 1'b0, a, l};
    waitRdy();
    chk("ready", 0, busReqReady);
    look(0, 0, a, 1);
    chk("busy", 1, busWrite_r);
    while (busWrite_r === 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    chk("wline", l, wrLine);
    chk("wclocks", 5, wrClk);
  endtask
  task automatic stby(input logic r);
    @(negedge clock);
    lowPowerStop = 1'b1;
    @(negedge clock);
    lowPowerStop = 1'b0;
    coreReq.valid = 1'b1;
    #1;
    chk("stby", 1, standby_r);
    chk("grant", 0, coreGrant);
    chk("bready", 0, busReqReady);
    coreReq.valid = 1'b0;
    repeat (3) @(negedge clock);
    chk("stay", 1, standby_r);
    if (r)
      srst = 1'b1;
    else
      intValid = 1'b1;
    @(negedge clock);
    {srst, intValid} = 2'h0;
    chk("wake", 0, standby_r);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    #2000000;
    error_cnt++;
    test_done();
  end
  initial
  begin
    repeat (2) @(negedge clock);
    srst = 1'b0;
    look(0, 0, A, 0);
    slow = 1'b1;
    fill(0, A);
    slow = 1'b0;
    look(0, 0, A, 1);
    look(1, 0, A, 0);
    snp(0, 0, A, 0);
    snp(0, 1, A, 0);
    look(0, 1, A, 1);
    snp(0, 1, A, 1);
    snp(1, 0, A, 0);
    look(0, 0, A, 1);
    snp(1, 1, A, 1);
    look(0, 0, A, 0);
    fill(1, B);
    snp(0, 1, B, 0);
    look(1, 0, B, 1);
    snp(1, 1, B, 0);
    look(1, 0, B, 0);
    fill(0, A);
    prio(A);
    cb(A, 128'h44444444_33333333_22222222_11111111);
    stby(0);
    stby(1);
    look(0, 0, A, 0);
    test_done();
  end
endmodule
